// ==== tcc_regs.svh ====
// Register offsets, field positions and reset values of the channel pair
// capture/compare block. Byte addresses on a 32-bit Avalon-MM slave.
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
`define TCC_ADDR_W        8
`define TCC_OFS_PAIR_CTL  8'h1c
`define TCC_OFS_EN_POL    8'h20
`define TCC_OFS_CH2_CV    8'h3c
`define TCC_OFS_CH3_CV    8'h40
`define TCC_OFS_PROTECTION_LEVEL      8'h44
`define TCC_OFS_CH2_ADD   8'h50
`define TCC_OFS_STATUS    8'h54
`define TCC_RST_PAIR_CTL  32'h0000_0000
`define TCC_RST_EN_POL    16'h0000
`define TCC_RST_CV        16'h0000
`define TCC_PROTECTION_LEVEL_POS      8
`define TCC_PROTECTION_LEVEL_LOCKED   2'h3
`define TCC_DIR_HI_POS    30
`define TCC_EP_CH2_BASE   8
`define TCC_EP_STRIDE     4
`define TCC_MSEL_BOTH     2'h3
`define TCC_MSEL_MAIN     2'h0
`endif

// ==== tcc_pkg.sv ====
// Types shared by the channel pair capture/compare block.
// Assumes the constants of tcc_regs.svh.
package tcc_pkg;
	typedef struct packed
	{
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} tcc_avs_req_s;

	typedef enum logic [7:0]
	{
		TCC_CMP_HOLD  = 8'h01,
		TCC_CMP_SET   = 8'h02,
		TCC_CMP_CLR   = 8'h04,
		TCC_CMP_TOG   = 8'h08,
		TCC_CMP_LOW   = 8'h10,
		TCC_CMP_HIGH  = 8'h20,
		TCC_CMP_PWM0  = 8'h40,
		TCC_CMP_PWM1  = 8'h80
	} tcc_cmp_e;

	typedef struct packed
	{
		logic             ack;
		logic [31:0]      rdata;
		logic [1:0][7:0]  ctl;
		logic [1:0]       dir_hi;
		logic [15:0]      en_pol;
		logic [1:0]       protection_level;
		logic [1:0][15:0] cv;
		logic [1:0][15:0] cv_pre;
		logic [15:0]      add_cv;
		logic [1:0]       cref;
		logic [3:0]       flt;
		logic [3:0][3:0]  flt_cnt;
		logic [4:0]       div;
		logic [1:0]       sel_prev;
		logic [1:0][2:0]  psc_cnt;
		logic [1:0]       cap;
		logic [3:0]       pin;
	} tcc_state_s;
endpackage

// ==== tcc_pair.sv ====
// Capture/compare logic of timer channels 2 and 3 with the enable/polarity
// register; an Avalon-MM slave with registered waitrequest.
// Assumes counter, update event, trigger and multi-mode selects come from
// the timer core, all synchronous to clk_sys_i.
//
// Functional notes
// - Channel 3 direction codes select input source
// - Channel 3 direction locked while channel active
// - Channel 2 direction codes select input source
// - Channel 2 direction locked while channel active
// - Trigger input only when trigger source selected
// - External trigger clears reference when enabled
// - Compare modes hold, set, clear, toggle, force
// - PWM mode 0 reference levels
// - PWM mode 1 reference levels
// - PWM level changes only on comparison/mode
// - Composite PWM uses both compare values
// - Compare mode locked under full protection
// - Shadowed compare value loads on update
// - Multi output shares reference, own polarity
// - Input filter needs N equal samples
// - Capture prescaler 1, 2, 4, 8 edges
// - Prescaler cleared while channel disabled
// - Input mode reinterprets control bits
// - Four enable/polarity bits per channel
// - Half-word and word access to enables
// - Enable gates output or capture
// - Polarity: output level or capture edge
`timescale 1ns/100ps
`include "tcc_regs.svh"
module tcc_pair
(
	input  wire logic                  clk_sys_i,
	input  wire logic                  sys_rst_i,
	input  wire tcc_pkg::tcc_avs_req_s avs_req_i,
	output logic [31:0]                avs_readdata_o,
	output logic                       avs_waitrequest_o,
	input  wire logic [15:0]           counter_value_i,
	input  wire logic                  count_down_i,
	input  wire logic                  update_evt_i,
	input  wire logic                  filtered_ext_trigger_i,
	input  wire logic                  internal_trigger_sig_i,
	input  wire logic                  trigger_source_valid_i,
	input  wire logic                  ch2_composite_pwm_en_i,
	input  wire logic [1:0]            ch2_multi_mode_sel_i,
	input  wire logic [1:0]            ch3_multi_mode_sel_i,
	input  wire logic [3:0]            chan_in_i,
	output logic                       ch2_output_pin_o,
	output logic                       ch2_multi_output_pin_o,
	output logic                       ch3_output_pin_o,
	output logic                       ch3_multi_output_pin_o,
	output logic [1:0]                 capture_o
);
	import tcc_pkg::*;

	tcc_state_s st;
	tcc_state_s n;

	////////////////////////////////////////////////////////////////////////
	// Filter sample count per code; zero means no filtering.
	function automatic logic [3:0] flt_need(input logic [3:0] c);
		case (c)
			4'h1: flt_need = 4'h2;
			4'h2: flt_need = 4'h4;
			4'h4, 4'h6, 4'h8, 4'hb, 4'he: flt_need = 4'h6;
			4'ha, 4'hd: flt_need = 4'h5;
			4'h0: flt_need = 4'h0;
			default: flt_need = 4'h8;
		endcase
	endfunction

	// Divider mask of the sample rate; the dead-time clock equals clk.
	function automatic logic [4:0] flt_mask(input logic [3:0] c);
		if (c < 4'h4)
			flt_mask = 5'h00;
		else if (c < 4'h6)
			flt_mask = 5'h01;
		else if (c < 4'h8)
			flt_mask = 5'h03;
		else if (c < 4'ha)
			flt_mask = 5'h07;
		else if (c < 4'hd)
			flt_mask = 5'h0f;
		else
			flt_mask = 5'h1f;
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] o,
		input logic [7:0] w, input logic be);
		merge = be ? w : o;
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic [31:0] rd;
	logic [2:0]  dir [2];
	logic        wr;
	logic        adr_ctl;

	always_comb
	begin
		rd = 32'h0000_0000;
		for (int i = 0; i < 2; i++)
			dir[i] = {st.dir_hi[i], st.ctl[i][1:0]};
		wr = st.ack & avs_req_i.write;
		adr_ctl = avs_req_i.address == `TCC_OFS_PAIR_CTL;
		if (adr_ctl)
		begin
			rd[31:30] = {st.dir_hi[1], st.dir_hi[0]};
			rd[15:8] = st.ctl[1] & ((dir[1] == 3'h0) ? 8'hfb : 8'hff);
			rd[7:0] = st.ctl[0] & ((dir[0] == 3'h0) ? 8'hfb : 8'hff);
		end
		else if (avs_req_i.address == `TCC_OFS_EN_POL)
			rd[15:0] = st.en_pol;
		else if (avs_req_i.address == `TCC_OFS_CH2_CV)
			rd[15:0] = st.cv[0];
		else if (avs_req_i.address == `TCC_OFS_CH3_CV)
			rd[15:0] = st.cv[1];
		else if (avs_req_i.address == `TCC_OFS_PROTECTION_LEVEL)
			rd[9:8] = st.protection_level;
		else if (avs_req_i.address == `TCC_OFS_CH2_ADD)
			rd[15:0] = st.add_cv;
		else if (avs_req_i.address == `TCC_OFS_STATUS)
			rd[3:0] = {st.flt[1:0], st.cref};
	end

	////////////////////////////////////////////////////////////////////////
	logic [1:0] msel [2];
	logic       en [2];
	logic       men [2];
	logic       pol [2];
	logic       mpol [2];
	logic       sel [2];
	logic       edge_hit [2];
	logic       match;
	logic       below;
	logic       above;
	logic       pwm;
	logic       nref;
	logic [3:0] fcode;
	logic [3:0] need;
	logic [2:0] plim;
	logic [7:0] wb;
	tcc_cmp_e   md;

	always_comb
	begin
		n = st;
		n.cap = 2'h0;
		msel[0] = ch2_multi_mode_sel_i;
		msel[1] = ch3_multi_mode_sel_i;
		match = 1'b0;
		below = 1'b0;
		above = 1'b0;
		pwm = 1'b0;
		nref = 1'b0;
		fcode = 4'h0;
		need = 4'h0;
		plim = 3'h0;
		wb = 8'h00;
		md = TCC_CMP_HOLD;

		// Bus answer: one wait cycle, then waitrequest drops for one edge.
		if (st.ack)
			n.ack = 1'b0;
		else if (avs_req_i.read || avs_req_i.write)
		begin
			n.ack = 1'b1;
			n.rdata = rd;
		end

		n.div = st.div + 5'h01;
		for (int i = 0; i < 2; i++)
		begin
			en[i] = st.en_pol[`TCC_EP_CH2_BASE + `TCC_EP_STRIDE * i];
			pol[i] = st.en_pol[`TCC_EP_CH2_BASE + `TCC_EP_STRIDE * i + 1];
			men[i] = st.en_pol[`TCC_EP_CH2_BASE + `TCC_EP_STRIDE * i + 2];
			mpol[i] = st.en_pol[`TCC_EP_CH2_BASE + `TCC_EP_STRIDE * i + 3];
		end

		// Digital filters: k = ch2, ch3, ch2 multi, ch3 multi.
		for (int k = 0; k < 4; k++)
		begin
			fcode = st.ctl[k % 2][7:4];
			need = flt_need(fcode);
			if (fcode == 4'h0)
			begin
				n.flt[k] = chan_in_i[k];
				n.flt_cnt[k] = 4'h0;
			end
			else if ((st.div & flt_mask(fcode)) == 5'h00)
			begin
				if (chan_in_i[k] == st.flt[k])
					n.flt_cnt[k] = 4'h0;
				else if (st.flt_cnt[k] + 4'h1 >= need)
				begin
					n.flt[k] = chan_in_i[k];
					n.flt_cnt[k] = 4'h0;
				end
				else
					n.flt_cnt[k] = st.flt_cnt[k] + 4'h1;
			end
		end

		for (int i = 0; i < 2; i++)
		begin
			// Capture source and edge.
			case (dir[i])
				3'h1: sel[i] = st.flt[i];
				3'h2: sel[i] = st.flt[1 - i];
				3'h3: sel[i] = internal_trigger_sig_i
					& trigger_source_valid_i;
				3'h4: sel[i] = st.flt[2 + i];
				default: sel[i] = 1'b0;
			endcase
			n.sel_prev[i] = sel[i];
			case ({mpol[i], pol[i]})
				2'h0: edge_hit[i] = sel[i] & ~st.sel_prev[i];
				2'h1: edge_hit[i] = ~sel[i] & st.sel_prev[i];
				2'h3: edge_hit[i] = sel[i] ^ st.sel_prev[i];
				default: edge_hit[i] = 1'b0;
			endcase
			plim = 3'((1 << st.ctl[i][3:2]) - 1);
			if (!en[i])
				n.psc_cnt[i] = 3'h0;
			else if (dir[i] != 3'h0 && edge_hit[i])
			begin
				if (st.psc_cnt[i] >= plim)
				begin
					n.psc_cnt[i] = 3'h0;
					n.cap[i] = 1'b1;
					n.cv[i] = counter_value_i;
				end
				else
					n.psc_cnt[i] = st.psc_cnt[i] + 3'h1;
			end

			// Compare reference.
			match = counter_value_i == st.cv[i];
			below = counter_value_i < st.cv[i];
			above = counter_value_i > st.cv[i];
			pwm = count_down_i ? ~above : below;
			if (i == 0 && ch2_composite_pwm_en_i && dir[0] == 3'h0)
				pwm = counter_value_i < st.cv[0]
					|| counter_value_i >= st.add_cv;
			md = tcc_cmp_e'(8'h01 << st.ctl[i][6:4]);
			case (md)
				TCC_CMP_SET: nref = match ? 1'b1 : st.cref[i];
				TCC_CMP_CLR: nref = match ? 1'b0 : st.cref[i];
				TCC_CMP_TOG: nref = match ? ~st.cref[i] : st.cref[i];
				TCC_CMP_LOW: nref = 1'b0;
				TCC_CMP_HIGH: nref = 1'b1;
				TCC_CMP_PWM0: nref = pwm;
				TCC_CMP_PWM1: nref = ~pwm;
				default: nref = st.cref[i];
			endcase
			if (st.ctl[i][7] && filtered_ext_trigger_i)
				nref = 1'b0;
			n.cref[i] = (dir[i] == 3'h0) ? nref : 1'b0;
			if (update_evt_i && st.ctl[i][3] && dir[i] == 3'h0)
				n.cv[i] = st.cv_pre[i];

			// Pins from reference and polarity.
			n.pin[2 * i] = (dir[i] == 3'h0) & en[i]
				& (st.cref[i] ^ pol[i]);
			n.pin[2 * i + 1] = (dir[i] == 3'h0) & men[i]
				& (msel[i] == `TCC_MSEL_BOTH)
				& (st.cref[i] ^ mpol[i]);
		end

		// Register writes, taken at the edge where waitrequest is low.
		if (wr && adr_ctl)
		begin
			for (int i = 0; i < 2; i++)
			begin
				wb = merge(st.ctl[i], avs_req_i.writedata[8 * i +: 8],
					avs_req_i.byteenable[i]);
				if (st.protection_level == `TCC_PROTECTION_LEVEL_LOCKED && dir[i] == 3'h0)
					wb[6:3] = st.ctl[i][6:3];
				if (en[i] || (msel[i] != `TCC_MSEL_MAIN && men[i]))
					wb[1:0] = st.ctl[i][1:0];
				else if (avs_req_i.byteenable[3])
					n.dir_hi[i] =
						avs_req_i.writedata[`TCC_DIR_HI_POS + i];
				n.ctl[i] = wb;
			end
		end
		else if (wr && avs_req_i.address == `TCC_OFS_EN_POL)
		begin
			n.en_pol[7:0] = merge(st.en_pol[7:0],
				avs_req_i.writedata[7:0], avs_req_i.byteenable[0]);
			n.en_pol[15:8] = merge(st.en_pol[15:8],
				avs_req_i.writedata[15:8], avs_req_i.byteenable[1]);
		end
		else if (wr && avs_req_i.address == `TCC_OFS_PROTECTION_LEVEL
			&& avs_req_i.byteenable[1])
			n.protection_level = avs_req_i.writedata[`TCC_PROTECTION_LEVEL_POS +: 2];
		else if (wr && avs_req_i.address == `TCC_OFS_CH2_ADD)
			n.add_cv = avs_req_i.writedata[15:0];
		for (int i = 0; i < 2; i++)
			if (wr && dir[i] == 3'h0 && avs_req_i.address ==
				(i == 0 ? `TCC_OFS_CH2_CV : `TCC_OFS_CH3_CV))
			begin
				n.cv_pre[i] = avs_req_i.writedata[15:0];
				if (!st.ctl[i][3])
					n.cv[i] = avs_req_i.writedata[15:0];
			end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			st <= '0;
		else
			st <= n;
	end

	assign avs_readdata_o = st.rdata;
	assign avs_waitrequest_o = ~st.ack;
	assign ch2_output_pin_o = st.pin[0];
	assign ch2_multi_output_pin_o = st.pin[1];
	assign ch3_output_pin_o = st.pin[2];
	assign ch3_multi_output_pin_o = st.pin[3];
	assign capture_o = st.cap;
	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	property p_dir3_lock;
		wr && adr_ctl && en[1] |=> $stable(st.ctl[1][1:0]);
	endproperty
	a_dir3_lock: assert property (p_dir3_lock)
		else $error("ch3 direction changed while enabled");

	property p_dir2_lock;
		wr && adr_ctl && en[0] |=> $stable(st.ctl[0][1:0]);
	endproperty
	a_dir2_lock: assert property (p_dir2_lock)
		else $error("ch2 direction changed while enabled");

	property p_clear;
		st.ctl[0][7] && filtered_ext_trigger_i |=> !st.cref[0] ##1 !st.pin[0]
			|| st.en_pol[9];
	endproperty
	a_clear: assert property (p_clear)
		else $error("ext trigger did not clear reference");

	property p_force;
		dir[0] == 3'h0 && st.ctl[0][6:4] == 3'h4 |=> !st.cref[0];
	endproperty
	a_force: assert property (p_force)
		else $error("force low not applied");

	property p_pwm0;
		dir[0] == 3'h0 && st.ctl[0][7:4] == 4'h6 && !count_down_i
			&& counter_value_i < st.cv[0] |=> st.cref[0];
	endproperty
	a_pwm0: assert property (p_pwm0)
		else $error("pwm0 reference low below compare");

	property p_pwm1;
		dir[0] == 3'h0 && st.ctl[0][7:4] == 4'h7 && !count_down_i
			&& counter_value_i < st.cv[0] |=> !st.cref[0];
	endproperty
	a_pwm1: assert property (p_pwm1)
		else $error("pwm1 reference high below compare");

	property p_protection_level;
		wr && adr_ctl && st.protection_level == 2'h3 && dir[0] == 3'h0
			|=> $stable(st.ctl[0][6:3]);
	endproperty
	a_protection_level: assert property (p_protection_level)
		else $error("compare mode changed under protection");

	property p_shadow;
		st.ctl[0][3] && dir[0] == 3'h0 && !update_evt_i
			|=> $stable(st.cv[0]);
	endproperty
	a_shadow: assert property (p_shadow)
		else $error("shadowed compare value changed early");

	property p_psc_rst;
		!en[0] |=> st.psc_cnt[0] == 3'h0 && !st.cap[0];
	endproperty
	a_psc_rst: assert property (p_psc_rst)
		else $error("prescaler not cleared while disabled");

	property p_disabled_pin;
		!en[1] |=> !st.pin[2];
	endproperty
	a_disabled_pin: assert property (p_disabled_pin)
		else $error("ch3 pin active while disabled");

	c_capture: cover property (st.cap[0] ##[1:20] st.cap[0]);
	c_pwm: cover property ($rose(st.pin[0]) ##[1:50] $fell(st.pin[0]));
	c_write: cover property (wr && avs_req_i.byteenable == 4'h3);
endmodule

// ==== tcc_pins_model.sv ====
// Pin-side model of the timer channel inputs.
// Assumes one clock; pins change just after a rising edge.
`timescale 1ns/100ps
module tcc_pins_model
(
	input  wire logic       clk_sys_i,
	input  wire logic       go_i,
	input  wire logic [1:0] pin_sel_i,
	input  wire logic [3:0] hold_i,
	output logic [3:0]      chan_in_o
);
	logic [3:0] left;
	logic [1:0] sel;

	initial
	begin
		chan_in_o = 4'h0;
		left = 4'h0;
		sel = 2'h0;
	end

	// A request gives one high pulse of hold_i cycles on the chosen pin.
	always @(posedge clk_sys_i)
	begin
		if (left != 4'h0)
		begin
			left <= left - 4'h1;
			if (left == 4'h1)
				chan_in_o[sel] <= 1'b0;
		end
		else if (go_i)
		begin
			sel <= pin_sel_i;
			chan_in_o[pin_sel_i] <= 1'b1;
			left <= hold_i;
		end
	end
endmodule

// ==== tcc_pair_tb.sv ====
// Self-checking bench of the channel pair capture/compare block.
// Assumes the register map of tcc_regs.svh and one 40 MHz clock.
`timescale 1ns/100ps
`include "tcc_regs.svh"
module tcc_pair_tb;
	import tcc_pkg::*;
	logic         clk_sys_i;
	logic         sys_rst_i;
	tcc_avs_req_s req;
	logic [31:0]  rdata;
	logic         wait_r;
	logic [15:0]  cnt;
	logic         down;
	logic         upd;
	logic         ext;
	logic         go;
	logic [3:0]   pins;
	logic         p2;
	logic         m2;
	logic         p3;
	logic         m3;
	logic [1:0]   cap;
	logic [1:0]   msel;
	logic         cpwm;
	int           n_mismatch;
	int           compares;
	int           n_cap;
	int           n_cap3;
	int           cycles;

	tcc_pair dut
	(
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_req_i(req),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wait_r),
		.counter_value_i(cnt), .count_down_i(down), .update_evt_i(upd),
		.filtered_ext_trigger_i(ext), .internal_trigger_sig_i(1'b0),
		.trigger_source_valid_i(1'b0), .ch2_composite_pwm_en_i(cpwm),
		.ch2_multi_mode_sel_i(msel), .ch3_multi_mode_sel_i(msel),
		.chan_in_i(pins), .ch2_output_pin_o(p2),
		.ch2_multi_output_pin_o(m2), .ch3_output_pin_o(p3),
		.ch3_multi_output_pin_o(m3), .capture_o(cap)
	);

	tcc_pins_model pins_model
	(
		.clk_sys_i(clk_sys_i), .go_i(go), .pin_sel_i(2'h0),
		.hold_i(4'h4), .chan_in_o(pins)
	);

	initial
	begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cap[0] === 1'b1)
			n_cap++;
		if (cap[1] === 1'b1)
			n_cap3++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			test_done();
		end
	end

	task automatic test_done();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// Holds the request until waitrequest is seen low at a rising edge.
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
		req <= {!wr, wr, a, d, be};
		@(posedge clk_sys_i);
		while (wait_r !== 1'b0)
			@(posedge clk_sys_i);
		q = rdata;
		req <= '0;
		@(posedge clk_sys_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hf, q);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hf, q);
		chk(q, exp);
	endtask

	task automatic pin_chk(input logic [1:0] exp);
		repeat (3) @(posedge clk_sys_i);
		#1;
		chk({30'h0, p3, p2}, {30'h0, exp});
	endtask

	// Checks all four pins as {ch3 multi, ch3, ch2 multi, ch2}.
	task automatic mpin_chk(input logic [3:0] exp);
		repeat (3) @(posedge clk_sys_i);
		#1;
		chk({28'h0, m3, p3, m2, p2}, {28'h0, exp});
	endtask

	task automatic pulse();
		go <= 1'b1;
		@(posedge clk_sys_i);
		go <= 1'b0;
		repeat (12) @(posedge clk_sys_i);
	endtask

	task automatic t_regs();
		logic [31:0] q;
		rdchk(`TCC_OFS_EN_POL, 32'h0);
		wr(`TCC_OFS_EN_POL, 32'hffff_ffff);
		rdchk(`TCC_OFS_EN_POL, 32'h0000_ffff);
		bus(1'b1, `TCC_OFS_EN_POL, 32'h0000_0000, 4'h3, q);
		rdchk(`TCC_OFS_EN_POL, 32'h0);
		rdchk(8'hf0, 32'h0);
	endtask

	task automatic t_lock();
		wr(`TCC_OFS_EN_POL, 32'h1100);
		wr(`TCC_OFS_PAIR_CTL, 32'h0101);
		rdchk(`TCC_OFS_PAIR_CTL, 32'h0);
		wr(`TCC_OFS_EN_POL, 32'h0);
		wr(`TCC_OFS_PAIR_CTL, 32'h0101);
		rdchk(`TCC_OFS_PAIR_CTL, 32'h0101);
		wr(`TCC_OFS_PAIR_CTL, 32'h0);
	endtask

	task automatic t_force();
		wr(`TCC_OFS_PAIR_CTL, 32'h5050);
		wr(`TCC_OFS_EN_POL, 32'h1100);
		pin_chk(2'b11);
		wr(`TCC_OFS_EN_POL, 32'h3300);
		pin_chk(2'b00);
		wr(`TCC_OFS_PAIR_CTL, 32'h4040);
		pin_chk(2'b11);
		wr(`TCC_OFS_PROTECTION_LEVEL, 32'h0300);
		wr(`TCC_OFS_PAIR_CTL, 32'h5050);
		rdchk(`TCC_OFS_PAIR_CTL, 32'h4040);
		wr(`TCC_OFS_PROTECTION_LEVEL, 32'h0);
		wr(`TCC_OFS_EN_POL, 32'h1100);
		wr(`TCC_OFS_PAIR_CTL, 32'hd0d0);
		ext <= 1'b1;
		pin_chk(2'b00);
		ext <= 1'b0;
		pin_chk(2'b11);
	endtask

	task automatic t_match();
		wr(`TCC_OFS_PAIR_CTL, 32'h0040);
		wr(`TCC_OFS_CH2_CV, 32'h0010);
		cnt <= 16'h000f;
		wr(`TCC_OFS_PAIR_CTL, 32'h0010);
		pin_chk(2'b10);
		cnt <= 16'h0010;
		pin_chk(2'b11);
		wr(`TCC_OFS_PAIR_CTL, 32'h0020);
		pin_chk(2'b10);
	endtask

	task automatic t_pwm();
		wr(`TCC_OFS_CH2_CV, 32'h0);
		wr(`TCC_OFS_PAIR_CTL, 32'h0048);
		wr(`TCC_OFS_CH2_CV, 32'h0010);
		cnt <= 16'h0005;
		wr(`TCC_OFS_PAIR_CTL, 32'h0068);
		pin_chk(2'b10);
		upd <= 1'b1;
		@(posedge clk_sys_i);
		upd <= 1'b0;
		pin_chk(2'b11);
		down <= 1'b1;
		cnt <= 16'h0020;
		pin_chk(2'b10);
		wr(`TCC_OFS_PAIR_CTL, 32'h0078);
		pin_chk(2'b11);
		down <= 1'b0;
		cnt <= 16'h0005;
		pin_chk(2'b10);
		wr(`TCC_OFS_CH2_ADD, 32'h0030);
		cnt <= 16'h0040;
		wr(`TCC_OFS_PAIR_CTL, 32'h0068);
		pin_chk(2'b10);
		cpwm <= 1'b1;
		pin_chk(2'b11);
		cnt <= 16'h0020;
		pin_chk(2'b10);
		cpwm <= 1'b0;
	endtask

	task automatic t_capture();
		wr(`TCC_OFS_EN_POL, 32'h0);
		wr(`TCC_OFS_PAIR_CTL, 32'h0205);
		wr(`TCC_OFS_EN_POL, 32'h1100);
		cnt <= 16'h0abc;
		n_cap = 0;
		n_cap3 = 0;
		pulse();
		pulse();
		chk(n_cap, 32'h1);
		rdchk(`TCC_OFS_CH2_CV, 32'h0abc);
		rdchk(`TCC_OFS_CH3_CV, 32'h0abc);
		pulse();
		wr(`TCC_OFS_EN_POL, 32'h0);
		wr(`TCC_OFS_EN_POL, 32'h1100);
		pulse();
		chk(n_cap, 32'h1);
		pulse();
		chk(n_cap, 32'h2);
		chk(n_cap3, 32'h5);
	endtask

	task automatic t_multi();
		wr(`TCC_OFS_EN_POL, 32'h0);
		wr(`TCC_OFS_PAIR_CTL, 32'h5050);
		msel <= 2'h3;
		wr(`TCC_OFS_EN_POL, 32'h4400);
		wr(`TCC_OFS_PAIR_CTL, 32'h5151);
		rdchk(`TCC_OFS_PAIR_CTL, 32'h5050);
		wr(`TCC_OFS_EN_POL, 32'h5500);
		mpin_chk(4'b1111);
		wr(`TCC_OFS_EN_POL, 32'hdd00);
		mpin_chk(4'b0101);
		msel <= 2'h0;
		wr(`TCC_OFS_EN_POL, 32'h5500);
		mpin_chk(4'b0101);
	endtask

	initial
	begin
		sys_rst_i = 1'b1;
		req = '0;
		cnt = 16'h0;
		down = 1'b0;
		upd = 1'b0;
		ext = 1'b0;
		go = 1'b0;
		msel = 2'h0;
		cpwm = 1'b0;
		n_mismatch = 0;
		compares = 0;
		n_cap = 0;
		n_cap3 = 0;
		cycles = 0;
		repeat (2) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_sys_i);
		t_regs();
		t_lock();
		t_force();
		t_match();
		t_pwm();
		t_capture();
		t_multi();
		test_done();
	end
endmodule
